//--- dv/nest_core_model.sv
`timescale 1ns/100ps

// core stand-in: takes one offer per ack_go after ack_wait cycles, returns once per ret_go
module nest_core_model
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // controller side
   input wire logic IRQ_REQ,
   output logic CORE_ACK,
   output logic CORE_RET,
   // bench control
   input wire logic ack_go,
   input wire logic ret_go,
   input wire logic [3:0] ack_wait
);
   logic ag_r, rg_r, pend_r;
   logic [3:0] cnt_r;

   // requests are sampled on the rising edge so the bench may change them on the falling one
   always @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         ag_r <= 1'b0;
         rg_r <= 1'b0;
      end
      else
      begin
         ag_r <= ack_go;
         rg_r <= ret_go;
      end
   end

   always @(negedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         CORE_ACK <= 1'b0;
         CORE_RET <= 1'b0;
         pend_r <= 1'b0;
         cnt_r <= 4'h0;
      end
      else
      begin
         CORE_RET <= rg_r;
         CORE_ACK <= 1'b0;
         if (ag_r)
            pend_r <= 1'b1;
         // only an offer that is still shown is taken
         if (pend_r && IRQ_REQ && !CORE_ACK)
         begin
            if (cnt_r == ack_wait)
            begin
               CORE_ACK <= 1'b1;
               pend_r <= 1'b0;
               cnt_r <= 4'h0;
            end
            else
               cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule : nest_core_model

//--- dv/tb.sv
`timescale 1ns/100ps

module tb
   import nest_irq_pkg::*;
;
   logic clk_sys, rst, global_mask, core_ack, core_ret, irq_req, thread_ok, ack_go, ret_go;
   logic [NUM_SRC-1:0] src_irq, enable_state, pending_state;
   logic [GRP_W-1:0] grouping;
   ena_cmd_t ena_cmd;
   prio_wr_t prio_wr;
   vec_wr_t vec_wr;
   logic [SRC_W-1:0] irq_id, active_id;
   logic [ADDR_W-1:0] irq_addr;
   logic [DEPTH_W-1:0] nest_depth;
   logic [3:0] ack_wait;
   int bad_count, n_checks;
   logic [GRP_W-1:0] grp_tab [4] = '{3'h3, 3'h7, 3'h1, 3'h2};
   logic pre_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

   nest_irq_ctrl i_dut (.CLK_SYS(clk_sys), .RST(rst), .SRC_IRQ(src_irq),
      .GLOBAL_MASK(global_mask), .GROUPING(grouping), .ENA_CMD(ena_cmd), .PRIO_WR(prio_wr),
      .VEC_WR(vec_wr), .CORE_ACK(core_ack), .CORE_RET(core_ret), .IRQ_REQ(irq_req),
      .IRQ_ID(irq_id), .IRQ_ADDR(irq_addr), .ENABLE_STATE(enable_state),
      .PENDING_STATE(pending_state), .NEST_DEPTH(nest_depth), .ACTIVE_ID(active_id),
      .THREAD_OK(thread_ok));

   nest_core_model i_core (.CLK_SYS(clk_sys), .RST(rst), .IRQ_REQ(irq_req),
      .CORE_ACK(core_ack), .CORE_RET(core_ret), .ack_go(ack_go), .ret_go(ret_go),
      .ack_wait(ack_wait));

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic results();
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] va(input int i);
      return 32'h4000_0000 + 32'(i) * 32'h10;
   endfunction : va

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic cfg(input int i, input logic [7:0] p);
      prio_wr = '{1'b1, 5'(i), p};
      vec_wr = '{1'b1, 5'(i), va(i)};
      cyc(1);
      prio_wr.valid = 1'b0;
      vec_wr.valid = 1'b0;
   endtask : cfg

   task automatic ena(input logic s, input int i);
      ena_cmd = '{1'b1, s, 5'(i)};
      cyc(1);
      ena_cmd.valid = 1'b0;
   endtask : ena

   // bounded wait for an offer, or for a nesting depth
   task automatic wfor(input logic on_req, input logic [DEPTH_W-1:0] d);
      int k;
      k = 0;
      while (k < 20 && !(on_req ? irq_req === 1'b1 : nest_depth === d))
      begin
         k++;
         cyc(1);
      end
      if (k == 20)
      begin
         bad_count++;
         $display("MISMATCH %0t wait ran out", $time);
         results();
      end
   endtask : wfor

   task automatic take(input int i, input logic [DEPTH_W-1:0] d);
      wfor(1'b1, 4'h0);
      chk(32'(irq_id), i);
      chk(irq_addr, va(i));
      ack_go = 1'b1;
      cyc(1);
      ack_go = 1'b0;
      wfor(1'b0, d);
      chk(32'(active_id), i);
      chk(32'(pending_state[i]), 32'h0);
   endtask : take

   task automatic ret(input logic [DEPTH_W-1:0] d);
      ret_go = 1'b1;
      cyc(1);
      ret_go = 1'b0;
      wfor(1'b0, d);
   endtask : ret

   initial
   begin
      rst = 1'b1;
      src_irq = '0;
      global_mask = 1'b0;
      grouping = 3'h0;
      ena_cmd = '0;
      prio_wr = '0;
      vec_wr = '0;
      ack_go = 1'b0;
      ret_go = 1'b0;
      ack_wait = 4'h0;
      bad_count = 0;
      n_checks = 0;
      cyc(5);
      rst = 1'b0;
      cyc(1);
      chk(enable_state | pending_state, 32'h0);
      chk(32'({nest_depth, irq_req, thread_ok}), 32'h1);
      for (int i = 0; i < NUM_SRC; i++)
      begin
         ena(1'b1, i);
         cfg(i, 8'h00);
      end
      chk(enable_state, 32'hffff_ffff);
      // equal priority, simultaneous: lower number first, the other tail chains
      src_irq[9] = 1'b1;
      src_irq[4] = 1'b1;
      cyc(3);
      src_irq = '0;
      chk(pending_state, 32'h0000_0210);
      take(4, 4'h1);
      cyc(3);
      chk(32'(irq_req), 32'h0);
      ret(4'h0);
      chk(32'(thread_ok), 32'h0);
      take(9, 4'h1);
      ret(4'h0);
      cyc(2);
      chk(32'(thread_ok), 32'h1);
      // low bits of 12 are ignored, 20 is least urgent
      cfg(4, 8'h60);
      cfg(12, 8'h5f);
      cfg(20, 8'h80);
      // groupings 3 and 7 alike, 1 and 2 leave 4 and 12 on one level
      for (int g = 0; g < 4; g++)
      begin
         grouping = grp_tab[g];
         ack_wait = 4'(g * 2);
         src_irq[4] = 1'b1;
         cyc(3);
         src_irq[4] = 1'b0;
         take(4, 4'h1);
         src_irq[12] = 1'b1;
         src_irq[20] = 1'b1;
         cyc(3);
         src_irq = '0;
         cyc(2);
         chk(32'(irq_req), 32'(pre_tab[g]));
         if (pre_tab[g])
         begin
            take(12, 4'h2);
            cyc(3);
            chk(32'(irq_req), 32'h0);
            ret(4'h1);
            chk(32'(active_id), 32'h4);
            ret(4'h0);
         end
         else
         begin
            ret(4'h0);
            take(12, 4'h1);
            ret(4'h0);
         end
         take(20, 4'h1);
         ret(4'h0);
      end
      // global mask blocks delivery, enables untouched
      global_mask = 1'b1;
      src_irq[7] = 1'b1;
      cyc(3);
      src_irq[7] = 1'b0;
      cyc(3);
      chk(32'({irq_req, pending_state[7]}), 32'h1);
      chk(enable_state, 32'hffff_ffff);
      global_mask = 1'b0;
      take(7, 4'h1);
      ret(4'h0);
      // controller disable: a raised line is never delivered
      ena(1'b0, 7);
      chk(enable_state, 32'hffff_ff7f);
      src_irq[7] = 1'b1;
      cyc(6);
      src_irq[7] = 1'b0;
      chk(32'({irq_req, pending_state[7]}), 32'h0);
      results();
   end
endmodule : tb

//--- verilog/nest_irq_arb.sv
`timescale 1ns/100ps

module nest_irq_arb
   import nest_irq_pkg::*;
(
   // candidates
   input wire logic [NUM_SRC-1:0] req,
   input wire logic [NUM_SRC-1:0][IMPL_W-1:0] prio,
   // winner
   output logic found,
   output logic [SRC_W-1:0] win_id,
   output logic [IMPL_W-1:0] win_prio
);

   // strict less-than keeps the lowest index on equal priority
   always_comb
   begin
      found = 1'b0;
      win_id = ID_RST;
      win_prio = PRIO_LOWEST;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (req[i] && (!found || prio[i] < win_prio))
         begin
            found = 1'b1;
            win_id = SRC_W'(i);
            win_prio = prio[i];
         end
      end
   end

endmodule : nest_irq_arb

//--- verilog/nest_irq_ctrl.sv
`timescale 1ns/100ps

module nest_irq_ctrl
   import nest_irq_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // peripheral interrupt lines
   input wire logic [NUM_SRC-1:0] SRC_IRQ,
   // software configuration
   input wire logic GLOBAL_MASK,
   input wire logic [GRP_W-1:0] GROUPING,
   input wire ena_cmd_t ENA_CMD,
   input wire prio_wr_t PRIO_WR,
   input wire vec_wr_t VEC_WR,
   // processor core
   input wire logic CORE_ACK,
   input wire logic CORE_RET,
   output logic IRQ_REQ,
   output logic [SRC_W-1:0] IRQ_ID,
   output logic [ADDR_W-1:0] IRQ_ADDR,
   // status
   output logic [NUM_SRC-1:0] ENABLE_STATE,
   output logic [NUM_SRC-1:0] PENDING_STATE,
   output logic [DEPTH_W-1:0] NEST_DEPTH,
   output logic [SRC_W-1:0] ACTIVE_ID,
   output logic THREAD_OK
);

   logic [NUM_SRC-1:0] src_s1_r;
   logic [NUM_SRC-1:0] src_s2_r;
   logic [NUM_SRC-1:0] enable_r;
   logic [NUM_SRC-1:0] enable_nxt;
   logic [NUM_SRC-1:0] pend_r;
   logic [NUM_SRC-1:0] pend_nxt;
   logic [NUM_SRC-1:0][IMPL_W-1:0] prio_r;
   logic [NUM_SRC-1:0][IMPL_W-1:0] prio_nxt;
   logic [ADDR_W-1:0] vec_r [NUM_SRC];
   logic [ADDR_W-1:0] vec_nxt [NUM_SRC];
   logic [GRP_W-1:0] grp_r;
   logic [MAX_DEPTH-1:0][SRC_W-1:0] stk_r;
   logic [MAX_DEPTH-1:0][SRC_W-1:0] stk_nxt;
   logic [DEPTH_W-1:0] depth_r;
   logic [DEPTH_W-1:0] depth_nxt;
   state_t state_r;
   state_t state_nxt;
   logic req_r;
   logic req_nxt;
   logic [SRC_W-1:0] id_r;
   logic [SRC_W-1:0] id_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [ADDR_W-1:0] addr_nxt;
   logic [SRC_W-1:0] act_r;
   logic [SRC_W-1:0] act_nxt;
   logic thread_ok_r;
   logic thread_ok_nxt;
   logic [NUM_SRC-1:0] ena_prev_r;

   logic win_found;
   logic [SRC_W-1:0] win_id;
   logic [IMPL_W-1:0] win_prio;
   logic ack_take;
   logic ret_take;
   logic [STK_W-1:0] top_idx;
   logic [SRC_W-1:0] top_id;
   logic [IMPL_W-1:0] pmask;
   logic [IMPL_W-1:0] win_lvl;
   logic [IMPL_W-1:0] top_lvl;
   logic elig;

   // preemption bits taken from the top of the implemented field
   function automatic logic [IMPL_W-1:0] preempt_mask(input logic [GRP_W-1:0] grp);
      logic [GRP_W-1:0] pb;
      pb = (grp >= GRP_W'(IMPL_W)) ? GRP_W'(IMPL_W) : grp;
      return ~(PRIO_LOWEST >> pb);
   endfunction : preempt_mask

   nest_irq_arb u_arb (
      .req(pend_r & enable_r),
      .prio(prio_r),
      .found(win_found),
      .win_id(win_id),
      .win_prio(win_prio)
   );

   assign ack_take = CORE_ACK && req_r;
   assign ret_take = CORE_RET && (depth_r != DEPTH_RST) && !ack_take;
   assign top_idx = STK_W'(depth_r - DEPTH_ONE);
   assign top_id = stk_r[top_idx];
   assign pmask = preempt_mask(grp_r);
   assign win_lvl = win_prio & pmask;
   assign top_lvl = prio_r[top_id] & pmask;

   // preemption needs a strictly more urgent preemption level
   assign elig = win_found && !GLOBAL_MASK && depth_r != DEPTH_FULL
      && (depth_r == DEPTH_RST || win_lvl < top_lvl);

   // per-source enable, pending latch, priority and handler address
   for (genvar i = 0; i < NUM_SRC; i++)
   begin : g_src
      always_comb
      begin
         enable_nxt[i] = enable_r[i];
         if (ENA_CMD.valid && ENA_CMD.idx == SRC_W'(i))
         begin
            enable_nxt[i] = ENA_CMD.set;
         end
         // a new request in the entry cycle wins over the clear
         pend_nxt[i] = (src_s2_r[i] && enable_r[i])
            || (pend_r[i] && !(ack_take && id_r == SRC_W'(i)));
         prio_nxt[i] = prio_r[i];
         if (PRIO_WR.valid && PRIO_WR.idx == SRC_W'(i))
         begin
            prio_nxt[i] = PRIO_WR.value[PRIO_MSB:PRIO_LSB];
         end
         vec_nxt[i] = vec_r[i];
         if (VEC_WR.valid && VEC_WR.idx == SRC_W'(i))
         begin
            vec_nxt[i] = VEC_WR.addr;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         src_s1_r <= PEND_RST;
         src_s2_r <= PEND_RST;
         enable_r <= ENABLE_RST;
         pend_r <= PEND_RST;
         ena_prev_r <= ENABLE_RST;
         grp_r <= GRP_RST;
         for (int i = 0; i < NUM_SRC; i++)
         begin
            prio_r[i] <= PRIO_RST;
            vec_r[i] <= VEC_RST;
         end
      end
      else
      begin
         src_s1_r <= SRC_IRQ;
         src_s2_r <= src_s1_r;
         enable_r <= enable_nxt;
         pend_r <= pend_nxt;
         ena_prev_r <= enable_r;
         grp_r <= GROUPING;
         prio_r <= prio_nxt;
         vec_r <= vec_nxt;
      end
   end

   // dispatch state, nesting stack and core-facing outputs
   always_comb
   begin
      state_nxt = state_r;
      stk_nxt = stk_r;
      depth_nxt = depth_r;
      case (state_r)
         S_THREAD:
            if (elig)
            begin
               state_nxt = S_OFFER;
            end
         S_OFFER:
            if (ack_take)
            begin
               state_nxt = S_ACTIVE;
            end
            else if (!elig)
            begin
               state_nxt = S_THREAD;
            end
         S_ACTIVE:
            if (ret_take)
            begin
               state_nxt = (depth_r == DEPTH_ONE) ? S_THREAD : S_ACTIVE;
            end
            else if (elig)
            begin
               state_nxt = S_PREEMPT;
            end
         S_PREEMPT:
            if (ack_take)
            begin
               state_nxt = S_ACTIVE;
            end
            else if (ret_take)
            begin
               state_nxt = (depth_r == DEPTH_ONE) ? S_THREAD : S_ACTIVE;
            end
            else if (!elig)
            begin
               state_nxt = S_ACTIVE;
            end
         default:
            state_nxt = S_THREAD;
      endcase
      if (ack_take)
      begin
         stk_nxt[STK_W'(depth_r)] = id_r;
         depth_nxt = depth_r + DEPTH_ONE;
      end
      else if (ret_take)
      begin
         depth_nxt = depth_r - DEPTH_ONE;
      end
      req_nxt = (state_nxt == S_OFFER) || (state_nxt == S_PREEMPT);
      id_nxt = req_nxt ? win_id : id_r;
      addr_nxt = req_nxt ? vec_r[win_id] : addr_r;
      act_nxt = (depth_nxt == DEPTH_RST) ? ID_RST : stk_nxt[STK_W'(depth_nxt - DEPTH_ONE)];
      thread_ok_nxt = (depth_nxt == DEPTH_RST) && (state_nxt == S_THREAD)
         && ((pend_nxt & enable_nxt) == PEND_RST);
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         state_r <= S_THREAD;
         stk_r <= '0;
         depth_r <= DEPTH_RST;
         req_r <= 1'b0;
         id_r <= ID_RST;
         addr_r <= VEC_RST;
         act_r <= ID_RST;
         thread_ok_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         stk_r <= stk_nxt;
         depth_r <= depth_nxt;
         req_r <= req_nxt;
         id_r <= id_nxt;
         addr_r <= addr_nxt;
         act_r <= act_nxt;
         thread_ok_r <= thread_ok_nxt;
      end
   end

   assign IRQ_REQ = req_r;
   assign IRQ_ID = id_r;
   assign IRQ_ADDR = addr_r;
   assign ENABLE_STATE = enable_r;
   assign PENDING_STATE = pend_r;
   assign NEST_DEPTH = depth_r;
   assign ACTIVE_ID = act_r;
   assign THREAD_OK = thread_ok_r;

   property p_mask_blocks;
      @(posedge CLK_SYS) disable iff (RST)
      GLOBAL_MASK && !ack_take |=> !req_r;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks)
      else $error("request offered while globally masked");

   property p_offer_enabled;
      @(posedge CLK_SYS) disable iff (RST)
      $rose(req_r) |-> ena_prev_r[id_r];
   endproperty
   a_offer_enabled: assert property (p_offer_enabled)
      else $error("disabled source offered to the core");

   property p_entry_push;
      @(posedge CLK_SYS) disable iff (RST)
      ack_take |=> depth_r == $past(depth_r) + DEPTH_ONE && act_r == $past(id_r) && !req_r;
   endproperty
   a_entry_push: assert property (p_entry_push)
      else $error("handler entry did not push the nesting stack");

   property p_return_pop;
      @(posedge CLK_SYS) disable iff (RST)
      ret_take |=> depth_r == $past(depth_r) - DEPTH_ONE;
   endproperty
   a_return_pop: assert property (p_return_pop)
      else $error("handler return did not pop the nesting stack");

   property p_thread_idle;
      @(posedge CLK_SYS) disable iff (RST)
      thread_ok_r |-> depth_r == DEPTH_RST && !req_r && (pend_r & enable_r) == PEND_RST;
   endproperty
   a_thread_idle: assert property (p_thread_idle)
      else $error("thread return allowed with work left");

   property p_entry_clears;
      @(posedge CLK_SYS) disable iff (RST)
      ack_take && !src_s2_r[id_r] |=> !pend_r[$past(id_r)];
   endproperty
   a_entry_clears: assert property (p_entry_clears)
      else $error("pending latch not cleared on handler entry");

   property p_pend_sets;
      @(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> ($past(src_s2_r) & $past(enable_r) & ~pend_r) == PEND_RST;
   endproperty
   a_pend_sets: assert property (p_pend_sets)
      else $error("enabled request did not set its pending latch");

   property p_preempt_level;
      @(posedge CLK_SYS) disable iff (RST)
      req_r && depth_r != DEPTH_RST && !$past(PRIO_WR.valid) && $stable(grp_r)
         |-> (prio_r[id_r] & pmask) < top_lvl;
   endproperty
   a_preempt_level: assert property (p_preempt_level)
      else $error("preemption offered without a more urgent level");

   property p_addr_match;
      @(posedge CLK_SYS) disable iff (RST)
      req_r && !$past(VEC_WR.valid) |-> addr_r == vec_r[id_r];
   endproperty
   a_addr_match: assert property (p_addr_match)
      else $error("handler address does not match offered source");

endmodule : nest_irq_ctrl

//--- verilog/nest_irq_pkg.sv
package nest_irq_pkg;

   // source and priority geometry
   localparam int NUM_SRC = 32;
   localparam int SRC_W = 5;
   localparam int PRIO_IN_W = 8;
   localparam int IMPL_W = 3;
   localparam int PRIO_MSB = PRIO_IN_W - 1;
   localparam int PRIO_LSB = PRIO_IN_W - IMPL_W;
   localparam int GRP_W = 3;
   localparam int ADDR_W = 32;

   // nesting stack: one entry per preemption level at most
   localparam int MAX_DEPTH = 8;
   localparam int STK_W = 3;
   localparam int DEPTH_W = 4;

   // reset values and fixed constants
   localparam logic [NUM_SRC-1:0] ENABLE_RST = 32'h0;
   localparam logic [NUM_SRC-1:0] PEND_RST = 32'h0;
   localparam logic [IMPL_W-1:0] PRIO_RST = 3'h0;
   localparam logic [IMPL_W-1:0] PRIO_LOWEST = 3'h7;
   localparam logic [ADDR_W-1:0] VEC_RST = 32'h0;
   localparam logic [GRP_W-1:0] GRP_RST = 3'h0;
   localparam logic [SRC_W-1:0] ID_RST = 5'h0;
   localparam logic [DEPTH_W-1:0] DEPTH_RST = 4'h0;
   localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
   localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;

   // dispatch state, gray coded along thread -> offer -> active -> preempt offer
   typedef enum logic [1:0] {
      S_THREAD = 2'b00,
      S_OFFER = 2'b01,
      S_ACTIVE = 2'b11,
      S_PREEMPT = 2'b10
   } state_t;

   // set or clear the controller-level enable of one source
   typedef struct packed {
      logic valid;
      logic set;
      logic [SRC_W-1:0] idx;
   } ena_cmd_t;

   // write one source priority field
   typedef struct packed {
      logic valid;
      logic [SRC_W-1:0] idx;
      logic [PRIO_IN_W-1:0] value;
   } prio_wr_t;

   // write one handler address
   typedef struct packed {
      logic valid;
      logic [SRC_W-1:0] idx;
      logic [ADDR_W-1:0] addr;
   } vec_wr_t;

endpackage : nest_irq_pkg
